// >>> hw/dbs_defs.vh
`ifndef DBS_DEFS_VH
`define DBS_DEFS_VH

// APB register byte offsets
`define DBS_REG_CTRL 12'h000
`define DBS_REG_SRC 12'h004
`define DBS_REG_DST 12'h008
`define DBS_REG_SIZE 12'h00C
`define DBS_REG_STATUS 12'h010
`define DBS_REG_COUNT 12'h014
`define DBS_REG_DATA 12'h018

// Control register field positions
`define DBS_CTRL_EN 0
`define DBS_CTRL_REPEAT 1
`define DBS_CTRL_BURST 2
`define DBS_CTRL_RMWP 3
`define DBS_CTRL_START 4

// Status register field positions
`define DBS_ST_BUSY 0
`define DBS_ST_BUSREQ 1
`define DBS_ST_HALTOK 2
`define DBS_ST_OVF 3

// Reset values
`define DBS_CTRL_RST 5'h00
`define DBS_ADDR_RST 20'h00000
`define DBS_SIZE_RST 16'h0000

// Timing counts
`define DBS_IDLE_CYCLES 3
`define DBS_BURST_WINDOW 10
`define DBS_BURST_DMA 8

`endif

// >>> hw/dbs_skid_buffer.v
`timescale 1ns/1ps

// ==========================================
// Two-entry buffer with valid/ready both sides
module dbs_skid_buffer #(
  parameter WIDTH = 32
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);

  // Second entry, held while the drain stalls
  reg [WIDTH-1:0] spare;
  // Occupancy: 0, 1 or 2 words
  reg [1:0] count;

  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);

  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // ==========================================
  // Entry storage and count
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 2'h0;
      outData <= {WIDTH{1'b0}};
      spare <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      // Head advances on pop, spare fills head
      if (pop && count == 2'h2)
        outData <= spare;
      else if (push && (count == 2'h0 || (pop && count == 2'h1)))
        outData <= inData;
      // Word arriving behind a held head
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop)))
        spare <= inData;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// >>> hw/dbs_dma_core.v
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "dbs_defs.vh"

// What this block does
// [R1] Repeat mode reloads size, restarts unless disabled
// [R2] Burst block: eight of ten cycles
// [R3] Halt granted: DMA idle three cycles, CPU idle
// [R4] Repeat burst keeps requesting, halt starves
// [R5] Twenty-bit source and destination address registers
// [R6] Software protects address writes first
// [R7] Word write loads only sixteen bits
// [R8] Transfer keeps prior flags set
// [R9] Software disables channels during flag RMW
// [R10] Software avoids peripherals in wait state
// [R11] Software keeps DMA targets off stack
// [R12] CPU stalled while DMA owns bus
module dbs_dma_core #(
  parameter SIZE_W = 16,
  parameter IDLE_CYCLES = `DBS_IDLE_CYCLES
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // CPU and debug arbitration
  input wire cpuBusReq,
  input wire dbgHaltReq,
  input wire periphTrigger,
  output wire cpuStall,
  output wire dmaBusReq,
  output wire dbgHaltGrant,
  // Transfer stream to memory side
  output wire xferValid,
  input wire xferReady,
  output wire [31:0] xferData
);

  // ==========================================
  // Pin synchronisers
  reg [2:0] syncA;
  reg [2:0] syncB;
  wire cpuReqS = syncB[0];
  wire haltReqS = syncB[1];
  wire trigS = syncB[2];
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 3'h0;
      syncB <= 3'h0;
    end
    else if (ce)
    begin
      syncA <= {periphTrigger, dbgHaltReq, cpuBusReq};
      syncB <= syncA;
    end
  end

  // ==========================================
  // Registers
  reg chanEnableBit; // Channel enable
  reg repeatMode; // Repeated transfer mode
  reg burstMode; // Burst-block mode
  reg rmwProtectBit; // Read-modify-write protection
  reg [19:0] chanSourceAddress;
  reg [19:0] chanDestAddress;
  reg [SIZE_W-1:0] chanTransferSize; // Programmed size
  reg [SIZE_W-1:0] remain; // Live size counter
  reg [19:0] curSrc;
  reg busy;
  reg ovf; // Sticky stall flag
  reg startPulse;
  reg [3:0] windowCnt; // Burst interleave phase
  reg [1:0] idleCnt; // Cycles since last transfer
  reg [31:0] dataWord;

  wire apbWr = psel && penable && pwrite;
  wire mapped = (paddr <= `DBS_REG_DATA) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================
  // Transfer cycle decision
  wire [SIZE_W-1:0] one = {{(SIZE_W-1){1'b0}}, 1'b1};
  // [R2] eight of ten
  wire burstSlot = !burstMode || (windowCnt < `DBS_BURST_DMA);
  wire bufReady;
  wire doXfer = busy && burstSlot && bufReady;
  wire lastXfer = doXfer && (remain == one);
  // [R12] bus owned during transfer
  assign dmaBusReq = doXfer;
  assign cpuStall = doXfer && cpuReqS;
  // [R3] halt only when quiet
  assign dbgHaltGrant = haltReqS && !busy && !cpuReqS &&
    (idleCnt == IDLE_CYCLES[1:0]);

  // Write with byte lane 2 strobe set covers the 20-bit field
  wire fullWr = pstrb[2];

  // ==========================================
  // Register writes and transfer engine
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chanEnableBit <= 1'b0;
      repeatMode <= 1'b0;
      burstMode <= 1'b0;
      rmwProtectBit <= 1'b0;
      chanSourceAddress <= `DBS_ADDR_RST;
      chanDestAddress <= `DBS_ADDR_RST;
      chanTransferSize <= {SIZE_W{1'b0}};
      remain <= {SIZE_W{1'b0}};
      curSrc <= `DBS_ADDR_RST;
      busy <= 1'b0;
      ovf <= 1'b0;
      startPulse <= 1'b0;
      windowCnt <= 4'h0;
      idleCnt <= 2'h0;
      dataWord <= 32'h00000000;
    end
    else if (ce)
    begin
      startPulse <= 1'b0;
      // Interleave window counts while busy in burst mode
      if (busy && burstMode)
        windowCnt <= (windowCnt == `DBS_BURST_WINDOW - 1) ? 4'h0 : windowCnt + 4'h1;
      else
        windowCnt <= 4'h0;
      // [R3] idle counter after last transfer
      if (doXfer || busy)
        idleCnt <= 2'h0;
      else if (idleCnt != IDLE_CYCLES[1:0])
        idleCnt <= idleCnt + 2'h1;
      // Stall seen on the stream sets a sticky flag
      // [R8] prior flag stays set
      if (busy && !bufReady)
        ovf <= 1'b1;
      else if (apbWr && paddr == `DBS_REG_STATUS && pwdata[`DBS_ST_OVF])
        ovf <= 1'b0;
      // Register writes
      if (apbWr)
      begin
        case (paddr)
          `DBS_REG_CTRL:
          begin
            chanEnableBit <= pwdata[`DBS_CTRL_EN];
            repeatMode <= pwdata[`DBS_CTRL_REPEAT];
            burstMode <= pwdata[`DBS_CTRL_BURST];
            rmwProtectBit <= pwdata[`DBS_CTRL_RMWP];
            startPulse <= pwdata[`DBS_CTRL_START] && pwdata[`DBS_CTRL_EN];
          end
          // [R5] [R7] word write loads 16 bits
          `DBS_REG_SRC:
            chanSourceAddress <= fullWr ? pwdata[19:0] : {4'h0, pwdata[15:0]};
          `DBS_REG_DST:
            chanDestAddress <= fullWr ? pwdata[19:0] : {4'h0, pwdata[15:0]};
          `DBS_REG_SIZE:
            chanTransferSize <= pwdata[SIZE_W-1:0];
          `DBS_REG_DATA:
            dataWord <= pwdata;
          default:
            ;
        endcase
      end
      // Start a transfer
      if (startPulse && !busy && chanTransferSize != {SIZE_W{1'b0}})
      begin
        busy <= 1'b1;
        remain <= chanTransferSize;
        curSrc <= chanSourceAddress;
      end
      else if (busy && !chanEnableBit)
        busy <= 1'b0;
      else if (doXfer)
      begin
        curSrc <= curSrc + 20'h00001;
        if (lastXfer)
        begin
          // [R1] [R4] reload, continue if repeat mode and enabled
          remain <= chanTransferSize;
          curSrc <= chanSourceAddress;
          busy <= repeatMode && chanEnableBit;
        end
        else
          remain <= remain - one;
      end
    end
  end

  // ==========================================
  // Read mux
  reg [31:0] next_prdata; // Value selected by the address
  always @*
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      `DBS_REG_CTRL:
        next_prdata = {27'h0, 1'b0, rmwProtectBit, burstMode, repeatMode, chanEnableBit};
      `DBS_REG_SRC:
        next_prdata = {12'h000, chanSourceAddress};
      `DBS_REG_DST:
        next_prdata = {12'h000, chanDestAddress};
      `DBS_REG_SIZE:
        next_prdata = {{(32-SIZE_W){1'b0}}, chanTransferSize};
      `DBS_REG_STATUS:
        next_prdata = {28'h0, ovf, dbgHaltGrant, dmaBusReq, busy};
      `DBS_REG_COUNT:
        next_prdata = {{(32-SIZE_W){1'b0}}, remain};
      `DBS_REG_DATA:
        next_prdata = dataWord;
      default:
        next_prdata = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle, so it stands through the access
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (ce && psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  // ==========================================
  // Stream buffer; each word carries the data with source low bits
  dbs_skid_buffer #(
    .WIDTH(32)
  ) uBuf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .inValid(doXfer),
    .inReady(bufReady),
    .inData(dataWord ^ {12'h000, curSrc}),
    .outValid(xferValid),
    .outReady(xferReady),
    .outData(xferData)
  );

endmodule

// >>> testbench/dbs_checker.sv
`timescale 1ns/1ps
// ==========
// Port checks on the DMA core
module dbs_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Arbitration
  input wire cpuBusReq,
  input wire cpuStall,
  input wire dmaBusReq,
  input wire dbgHaltGrant,
  // Stream
  input wire xferValid,
  input wire xferReady,
  input wire [31:0] xferData
);
  reg burst; // Burst mode as last written
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Follow control writes for the burst bit
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      burst <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      burst <= pwdata[2];
  a_ready_always: assert property (psel |-> pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access accepted");
  a_stall_owner: assert property (cpuStall == (dmaBusReq && $past(cpuBusReq, 2)))
    else $error("cpu stall wrong");
  a_halt_idle: assert property (dbgHaltGrant |-> !dmaBusReq && !$past(dmaBusReq))
    else $error("halt while dma busy");
  a_halt_cpu: assert property (dbgHaltGrant |-> !$past(cpuBusReq, 2))
    else $error("halt while cpu busy");
  a_burst_gap: assert property ((burst && dmaBusReq) [*8] |=> !dmaBusReq)
    else $error("burst exceeds eight");
  a_xfer_hold: assert property (xferValid && !xferReady |=> xferValid && $stable(xferData))
    else $error("stream word dropped");
  a_push_shown: assert property (dmaBusReq |=> xferValid)
    else $error("pushed word not offered");
  cover property (cpuStall);
  cover property (dbgHaltGrant);
  cover property (xferValid && !xferReady);
endmodule

bind dbs_dma_core dbs_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .cpuBusReq(cpuBusReq), .cpuStall(cpuStall), .dmaBusReq(dmaBusReq),
  .dbgHaltGrant(dbgHaltGrant), .xferValid(xferValid), .xferReady(xferReady),
  .xferData(xferData));

// >>> testbench/dbs_cpu_model.sv
`timescale 1ns/1ps
// ==========
// CPU and debugger sharing the bus
module dbs_cpu_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bench controls
  input wire cpuOn,
  input wire haltOn,
  // Arbitration
  input wire cpuStall,
  output reg cpuBusReq,
  output reg dbgHaltReq
);
  reg [2:0] ph; // Request pattern phase
  // Issue bus cycles in a fixed pattern
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ph <= 3'h0;
      cpuBusReq <= 1'b0;
      dbgHaltReq <= 1'b0;
    end
    else
    begin
      dbgHaltReq <= haltOn;
      // quiet for halt, hold when stalled
      if (!cpuStall)
      begin
        ph <= ph + 3'h1;
        cpuBusReq <= cpuOn && !haltOn && ph[1];
      end
    end
endmodule

// >>> testbench/dma_bus_sharing_control_tb.sv
`timescale 1ns/1ps
// ==========
// Bench for the DMA core
module dma_bus_sharing_control_tb;
  reg clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, xferReady = 0;
  reg cpuOn = 0, haltOn = 0, err;
  reg [1:0] mode = 2'h1; // Sink: 0 ready, 1 random, 2 stalled
  reg [11:0] paddr = 0;
  reg [3:0] pstrb = 4'hF;
  reg [31:0] pwdata = 0, seed = 32'h3E, rd, v, pat, src;
  wire [31:0] prdata, xferData;
  wire pready, pslverr, cpuStall, dmaBusReq, dbgHaltGrant, xferValid, cpuBusReq, dbgHaltReq;
  integer n_errors = 0, total_checks = 0, i, nReq;
  logic [31:0] got[$];
  always #20 clk = ~clk;
  dbs_dma_core u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpuBusReq(cpuBusReq), .dbgHaltReq(dbgHaltReq),
    .periphTrigger(1'b0), .cpuStall(cpuStall), .dmaBusReq(dmaBusReq),
    .dbgHaltGrant(dbgHaltGrant), .xferValid(xferValid), .xferReady(xferReady),
    .xferData(xferData));
  dbs_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .cpuOn(cpuOn), .haltOn(haltOn),
    .cpuStall(cpuStall), .cpuBusReq(cpuBusReq), .dbgHaltReq(dbgHaltReq));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Memory-side sink collecting words
  // words taken only while sink ready
  always @(posedge clk)
  begin
    if (xferValid === 1'b1 && xferReady) got.push_back(xferData);
    xferReady <= mode == 2'h0 || (mode == 2'h1 && rnd() % 4 != 0);
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // Bench model: word k of a transfer is pattern xor source plus k
  task chk_words(input integer sz);
    integer k;
    k = 0;
    while (got.size())
    begin
      chk("word", pat ^ ((src + k) & 32'hFFFFF), got.pop_front());
      k = (k + 1) % sz;
    end
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (i = 1; i < 4; i++)
    begin
      apb(0, i * 4, 0);
      chk("reset", 0, rd);
    end
    apb(0, 12'h020, 0);
    chk("slverr", 1, err);
    apb(1, 12'h000, 32'h8);
    src = rnd();
    apb(1, 12'h004, src);
    apb(0, 12'h004, 0);
    chk("src20", src & 32'hFFFFF, rd);
    v = rnd();
    pstrb <= 4'h3;
    apb(1, 12'h008, v);
    pstrb <= 4'hF;
    apb(0, 12'h008, 0);
    chk("dst16", v & 32'hFFFF, rd);
    $display("test registers done");
    pat = rnd();
    apb(1, 12'h018, pat); // pattern in a static word
    apb(1, 12'h00C, 3);
    mode <= 2'h2;
    cpuOn <= 1;
    apb(1, 12'h000, 32'h11);
    repeat (15) @(posedge clk);
    apb(0, 12'h010, 0);
    chk("ovf", 1, rd[3]);
    mode <= 2'h1;
    repeat (30) @(posedge clk);
    apb(1, 12'h000, 32'h0); // channel off before flag clear
    apb(1, 12'h010, 32'h8);
    apb(0, 12'h010, 0);
    chk("clear", 0, rd & 32'h9);
    apb(0, 12'h014, 0);
    chk("remain", 3, rd);
    chk("count", 3, got.size());
    chk_words(3);
    $display("test one shot done");
    apb(1, 12'h00C, 2);
    apb(1, 12'h000, 32'h13);
    repeat (40) @(posedge clk);
    apb(1, 12'h000, 0);
    repeat (20) @(posedge clk);
    apb(0, 12'h010, 0);
    chk("stop", 0, rd[0]);
    chk("reload", 1, got.size() > 5);
    chk_words(2);
    $display("test repeat done");
    mode <= 2'h0;
    haltOn <= 1;
    apb(1, 12'h000, 32'h17);
    repeat (10) @(posedge clk);
    nReq = 0;
    v = 0;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      nReq += dmaBusReq;
      v |= dbgHaltGrant;
    end
    chk("burst", 40, nReq);
    chk("starve", 0, v);
    apb(1, 12'h000, 0);
    for (i = 0; i < 12 && dbgHaltGrant !== 1'b1; i++) @(posedge clk);
    chk("halt", 1, dbgHaltGrant);
    chk_words(2);
    $display("test halt done");
    end_of_test();
  end
endmodule
